// ### logic/rtcal_defs.vh
// Constants for the alarm, control and square-wave logic of the RTC.
// Assumes a 10 MHz core clock and a 32.768 kHz oscillator on a pin.
`ifndef RTCAL_DEFS_VH
`define RTCAL_DEFS_VH

// Register offsets (7-bit pointer)
`define RTCAL_OFS_A1_SEC 7'h07
`define RTCAL_OFS_A1_MIN 7'h08
`define RTCAL_OFS_A1_HOUR 7'h09
`define RTCAL_OFS_A1_DAY 7'h0a
`define RTCAL_OFS_A2_MIN 7'h0b
`define RTCAL_OFS_A2_HOUR 7'h0c
`define RTCAL_OFS_A2_DAY 7'h0d
`define RTCAL_OFS_CTRL 7'h0e
`define RTCAL_OFS_STAT 7'h0f

// Control register fields
`define RTCAL_CTRL_OSC_STOP 7
`define RTCAL_CTRL_BACKUP_WAVE 6
`define RTCAL_CTRL_CONVERT 5
`define RTCAL_CTRL_RATE_HI 4
`define RTCAL_CTRL_RATE_LO 3
`define RTCAL_CTRL_IRQ_SEL 2
`define RTCAL_CTRL_A2_IE 1
`define RTCAL_CTRL_A1_IE 0
`define RTCAL_CTRL_RESET 8'h1c

// Status register fields
`define RTCAL_STAT_BUSY 2
`define RTCAL_STAT_A2F 1
`define RTCAL_STAT_A1F 0

// Alarm register fields
`define RTCAL_MASK_BIT 7
`define RTCAL_DYDT_BIT 6

// Timing
`define RTCAL_CLK_HZ 10000000
`define RTCAL_BUSY_DELAY_US 2000
`define RTCAL_FORCE_TEMP_CONVERT_TIME_US 100000
`define RTCAL_AUTO_FORCE_TEMP_CONVERT_SEC 64

// Prescaler taps on a 15-bit count of oscillator edges
`define RTCAL_PRESC_BITS 15
`define RTCAL_TAP_1HZ 14
`define RTCAL_TAP_1K 4
`define RTCAL_TAP_4K 2
`define RTCAL_TAP_8K 1

`endif

// ### logic/rtcal_spi_slave.v
// Serial register port: address byte, then data bytes with auto-increment.
// Assumes the host pins are asynchronous; all are double-synchronised.
`timescale 1ns/1ps

module rtcal_spi_slave (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire sclk_in,
  input wire cs_n_in,
  input wire din_in,
  input wire [7:0] rd_data_in,
  output wire [6:0] rd_addr_out,
  output reg [6:0] wr_addr_out,
  output reg [7:0] wr_data_out,
  output reg wr_stb_out,
  output reg dout_out,
  output wire dout_oe_out
);

  reg [1:0] sclk_sync;
  reg [1:0] cs_sync;
  reg [1:0] din_sync;
  reg sclk_d;
  reg cs_d;
  reg cpol;
  reg addr_phase;
  reg is_write;
  reg [2:0] bit_cnt;
  reg [6:0] in_sr;
  reg [7:0] out_sr;
  reg [6:0] ptr;
  wire sel;
  wire sclk_rise;
  wire sclk_fall;
  wire sample;
  wire launch;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only stage 2 (bit 1) is looked at by logic
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sclk_sync <= 2'h0;
      cs_sync <= 2'h3;
      din_sync <= 2'h0;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk_in};
      cs_sync <= {cs_sync[0], cs_n_in};
      din_sync <= {din_sync[0], din_in};
      sclk_d <= sclk_sync[1];
      cs_d <= cs_sync[1];
    end
  end

  assign sel = ~cs_sync[1];
  assign sclk_rise = sclk_sync[1] & ~sclk_d;
  assign sclk_fall = ~sclk_sync[1] & sclk_d;
  // Both clock-phase-one modes: sample on the trailing edge
  assign sample = sel & (cpol ? sclk_rise : sclk_fall);
  assign launch = sel & (cpol ? sclk_fall : sclk_rise);
  assign rd_addr_out = ptr;
  assign dout_oe_out = sel & ~addr_phase & ~is_write;

  ////////////////////////////////////////////////////////////////////////
  // Byte assembly, pointer and read shifter
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cpol <= 1'b0;
      addr_phase <= 1'b1;
      is_write <= 1'b0;
      bit_cnt <= 3'h0;
      in_sr <= 7'h00;
      out_sr <= 8'h00;
      ptr <= 7'h00;
      wr_addr_out <= 7'h00;
      wr_data_out <= 8'h00;
      wr_stb_out <= 1'b0;
      dout_out <= 1'b0;
    end else begin
      wr_stb_out <= 1'b0;
      if (cs_d && sel) begin
        // Idle clock level at select tells the mode apart
        cpol <= sclk_sync[1];
        addr_phase <= 1'b1;
        bit_cnt <= 3'h0;
      end else if (sample) begin
        in_sr <= {in_sr[5:0], din_sync[1]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          if (addr_phase) begin
            addr_phase <= 1'b0;
            is_write <= in_sr[6];
            ptr <= {in_sr[5:0], din_sync[1]};
          end else begin
            if (is_write) begin
              wr_stb_out <= 1'b1;
              wr_addr_out <= ptr;
              wr_data_out <= {in_sr, din_sync[1]};
            end
            ptr <= ptr + 7'h01;
          end
        end
      end else if (launch && !addr_phase && !is_write) begin
        if (bit_cnt == 3'h0) begin
          dout_out <= rd_data_in[7];
          out_sr <= {rd_data_in[6:0], 1'b0};
        end else begin
          dout_out <= out_sr[7];
          out_sr <= {out_sr[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ### logic/rtcal_alarm_ctrl.v
// Alarm comparators, control register, square wave and conversion control.
// Assumes calendar counters on the same clock supply current BCD time and
// advance on sec_tick_out; supply pins and the oscillator are asynchronous.
//
// Function
// - Alarm one lives at 07h-0Ah, alarm two at 0Bh-0Dh, host writable.
// - Bit 7 of each alarm register masks that field from comparison.
// - Alarm one masks select every second, or seconds up to day/date.
// - Alarm two all masked fires at seconds 00; clearing adds fields.
// - Day/date bit 6: zero compares month day, one compares weekday.
// - Matches are tested only at the once-per-second time update.
// - A match sets its flag regardless of select bit and enables.
// - Pin signals interrupt for flag set, its enable and select one.
// - Select zero puts square wave on pin; alarms never interrupt.
// - Rate bits 4:3 pick 1Hz, 1.024k, 4.096k or 8.192kHz.
// - Stop bit halts oscillator only on battery; registers freeze.
// - Below power fail, wave only with bit 6 and select zero.
// - Writing convert starts a conversion only when none is running.
// - Host conversion leaves the 64-second automatic cycle untouched.
// - Busy rises about 2ms late; convert bit clears with busy.
// - Control resets to rate bits and select one, others zero.
// - Interrupt drives pin low while enabled flag stays set.
// - Flags clear only by writing zero; writing one has no effect.
// - Time and alarm fields compare as stored BCD digits.
`timescale 1ns/1ps
`include "rtcal_defs.vh"

module rtcal_alarm_ctrl #(
  parameter BUSY_DELAY_CYC = `RTCAL_BUSY_DELAY_US * (`RTCAL_CLK_HZ / 1000000),
  parameter FORCE_TEMP_CONVERT_CYC = `RTCAL_FORCE_TEMP_CONVERT_TIME_US * (`RTCAL_CLK_HZ / 1000000),
  parameter CNT_W = 21
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire osc_32k_in,
  input wire on_battery_in,
  input wire below_pf_in,
  input wire spi_sclk_in,
  input wire spi_cs_n_in,
  input wire spi_din_in,
  output wire spi_dout_out,
  output wire spi_dout_oe_out,
  input wire [7:0] cur_sec_in,
  input wire [7:0] cur_min_in,
  input wire [7:0] cur_hour_in,
  input wire [7:0] cur_day_in,
  input wire [7:0] cur_date_in,
  output reg sec_tick_out,
  output reg osc_run_out,
  output reg compensation_busy_out,
  output reg temp_convert_start_out,
  output wire irq_wave_out,
  output reg irq_wave_oe_out
);

  localparam CV_IDLE = 3'b001;
  localparam CV_WAIT = 3'b010;
  localparam CV_BUSY = 3'b100;
  localparam integer WAIT_I = BUSY_DELAY_CYC - 1;
  localparam integer FORCE_TEMP_CONVERT_I = FORCE_TEMP_CONVERT_CYC - 1;
  localparam integer AUTO_I = `RTCAL_AUTO_FORCE_TEMP_CONVERT_SEC - 1;
  localparam [CNT_W-1:0] WAIT_LAST = WAIT_I[CNT_W-1:0];
  localparam [CNT_W-1:0] FORCE_TEMP_CONVERT_LAST = FORCE_TEMP_CONVERT_I[CNT_W-1:0];
  localparam [5:0] AUTO_LAST = AUTO_I[5:0];
  localparam PW = `RTCAL_PRESC_BITS;

  // Field compare: masked fields always agree
  function field_match;
    input mask;
    input [6:0] alarm;
    input [6:0] cur;
    begin
      field_match = mask | (alarm == cur);
    end
  endfunction

  // Day/date compare steered by the select bit
  function daydate_match;
    input [7:0] alarm;
    input [7:0] day;
    input [7:0] date;
    begin
      daydate_match = alarm[`RTCAL_MASK_BIT] |
        (alarm[5:0] == (alarm[`RTCAL_DYDT_BIT] ? day[5:0] : date[5:0]));
    end
  endfunction

  reg [7:0] a1_sec, a1_min, a1_hour, a1_day, a2_min, a2_hour, a2_day;
  reg [7:0] ctrl, rd_data;
  reg [2:0] osc_sync, cv_state;
  reg [1:0] batt_sync, pf_sync;
  reg [PW-1:0] presc;
  reg [5:0] auto_cnt;
  reg [CNT_W-1:0] cv_cnt;
  reg alarm_one_flag, alarm_two_flag, cmp_stb, auto_pend, host_run;
  reg wave, next_oe;
  wire [6:0] rd_addr, wr_addr;
  wire [7:0] wr_data;
  wire wr_stb, halt, osc_rise, wr_en, ctrl_wr, stat_wr, irq_sel;
  wire a1_hit, a2_hit, host_start, auto_due;

  rtcal_spi_slave u_port (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(spi_sclk_in),
    .cs_n_in(spi_cs_n_in),
    .din_in(spi_din_in),
    .rd_data_in(rd_data),
    .rd_addr_out(rd_addr),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_stb_out(wr_stb),
    .dout_out(spi_dout_out),
    .dout_oe_out(spi_dout_oe_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the oscillator gets a third stage for edge finding
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      osc_sync <= 3'h0;
      batt_sync <= 2'h0;
      pf_sync <= 2'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], osc_32k_in};
      batt_sync <= {batt_sync[0], on_battery_in};
      pf_sync <= {pf_sync[0], below_pf_in};
    end
  end

  assign osc_rise = osc_sync[1] & ~osc_sync[2];
  // Main supply overrides the stop request
  assign halt = batt_sync[1] & ctrl[`RTCAL_CTRL_OSC_STOP];
  // A halted part keeps every register static
  assign wr_en = wr_stb & ~halt;
  assign ctrl_wr = wr_en & (wr_addr == `RTCAL_OFS_CTRL);
  assign stat_wr = wr_en & (wr_addr == `RTCAL_OFS_STAT);
  assign irq_sel = ctrl[`RTCAL_CTRL_IRQ_SEL];

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and second tick; compare strobe trails the tick by a cycle
  // so the calendar has already stepped to the new second
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      presc <= {PW{1'b0}};
      sec_tick_out <= 1'b0;
      cmp_stb <= 1'b0;
      osc_run_out <= 1'b1;
    end else begin
      osc_run_out <= ~halt;
      sec_tick_out <= 1'b0;
      cmp_stb <= sec_tick_out;
      if (osc_rise && !halt) begin
        presc <= presc + 1'b1;
        if (&presc)
          sec_tick_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm matching on BCD fields
  assign a1_hit = field_match(a1_sec[7], a1_sec[6:0], cur_sec_in[6:0]) &
                  field_match(a1_min[7], a1_min[6:0], cur_min_in[6:0]) &
                  field_match(a1_hour[7], a1_hour[6:0], cur_hour_in[6:0]) &
                  daydate_match(a1_day, cur_day_in, cur_date_in);
  // Alarm two has no seconds field: it only fires at seconds 00
  assign a2_hit = (cur_sec_in[6:0] == 7'h00) &
                  field_match(a2_min[7], a2_min[6:0], cur_min_in[6:0]) &
                  field_match(a2_hour[7], a2_hour[6:0], cur_hour_in[6:0]) &
                  daydate_match(a2_day, cur_day_in, cur_date_in);

  ////////////////////////////////////////////////////////////////////////
  // Alarm registers, written whole, including mask and select bits
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      a1_sec <= 8'h00;
      a1_min <= 8'h00;
      a1_hour <= 8'h00;
      a1_day <= 8'h00;
      a2_min <= 8'h00;
      a2_hour <= 8'h00;
      a2_day <= 8'h00;
    end else if (wr_en) begin
      case (wr_addr)
        `RTCAL_OFS_A1_SEC: a1_sec <= wr_data;
        `RTCAL_OFS_A1_MIN: a1_min <= wr_data;
        `RTCAL_OFS_A1_HOUR: a1_hour <= wr_data;
        `RTCAL_OFS_A1_DAY: a1_day <= wr_data;
        `RTCAL_OFS_A2_MIN: a2_min <= wr_data;
        `RTCAL_OFS_A2_HOUR: a2_hour <= wr_data;
        `RTCAL_OFS_A2_DAY: a2_day <= wr_data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a match in the same cycle as a clearing write wins
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      alarm_one_flag <= 1'b0;
      alarm_two_flag <= 1'b0;
    end else begin
      alarm_one_flag <= (cmp_stb & a1_hit) | (alarm_one_flag &
        ~(stat_wr & ~wr_data[`RTCAL_STAT_A1F]));
      alarm_two_flag <= (cmp_stb & a2_hit) | (alarm_two_flag &
        ~(stat_wr & ~wr_data[`RTCAL_STAT_A2F]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; the convert bit is owned by the conversion logic
  assign host_start = ctrl_wr & wr_data[`RTCAL_CTRL_CONVERT] &
                      (cv_state == CV_IDLE);

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl <= `RTCAL_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl[7:6] <= wr_data[7:6];
        ctrl[4:0] <= wr_data[4:0];
      end
      if (host_start)
        ctrl[`RTCAL_CTRL_CONVERT] <= 1'b1;
      else if (cv_state == CV_BUSY && cv_cnt == FORCE_TEMP_CONVERT_LAST && host_run)
        ctrl[`RTCAL_CTRL_CONVERT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer. The automatic interval counts seconds on its own
  // and is never reset by a host request; a due slot that finds the
  // sequencer busy is held until it goes idle.
  assign auto_due = cmp_stb & (auto_cnt == AUTO_LAST);

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      auto_cnt <= 6'h00;
      auto_pend <= 1'b0;
      host_run <= 1'b0;
      cv_state <= CV_IDLE;
      cv_cnt <= {CNT_W{1'b0}};
      temp_convert_start_out <= 1'b0;
      compensation_busy_out <= 1'b0;
    end else begin
      temp_convert_start_out <= 1'b0;
      if (cmp_stb)
        auto_cnt <= auto_cnt + 6'h01;
      if (auto_due)
        auto_pend <= 1'b1;
      if (!halt) begin
        case (cv_state)
          CV_IDLE: begin
            cv_cnt <= {CNT_W{1'b0}};
            if (host_start) begin
              host_run <= 1'b1;
              cv_state <= CV_WAIT;
            end else if (auto_pend || auto_due) begin
              auto_pend <= 1'b0;
              temp_convert_start_out <= 1'b1;
              cv_state <= CV_BUSY;
            end
          end
          CV_WAIT: begin
            // Busy stays low through the start-up delay
            cv_cnt <= cv_cnt + 1'b1;
            if (cv_cnt == WAIT_LAST) begin
              cv_cnt <= {CNT_W{1'b0}};
              temp_convert_start_out <= 1'b1;
              cv_state <= CV_BUSY;
            end
          end
          CV_BUSY: begin
            cv_cnt <= cv_cnt + 1'b1;
            if (cv_cnt == FORCE_TEMP_CONVERT_LAST) begin
              host_run <= 1'b0;
              cv_state <= CV_IDLE;
            end
          end
          default: cv_state <= CV_IDLE;
        endcase
      end
      compensation_busy_out <= (cv_state == CV_BUSY) &&
                               !(cv_cnt == FORCE_TEMP_CONVERT_LAST && !halt);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared open-drain pin: interrupt or square wave. The wave pulls low in
  // its low half and releases in its high half.
  always @* begin
    case ({ctrl[`RTCAL_CTRL_RATE_HI], ctrl[`RTCAL_CTRL_RATE_LO]})
      2'h0: wave = presc[`RTCAL_TAP_1HZ];
      2'h1: wave = presc[`RTCAL_TAP_1K];
      2'h2: wave = presc[`RTCAL_TAP_4K];
      default: wave = presc[`RTCAL_TAP_8K];
    endcase
    if (irq_sel)
      next_oe = (alarm_one_flag & ctrl[`RTCAL_CTRL_A1_IE]) |
                (alarm_two_flag & ctrl[`RTCAL_CTRL_A2_IE]);
    else if (pf_sync[1] && !ctrl[`RTCAL_CTRL_BACKUP_WAVE])
      next_oe = 1'b0;
    else
      next_oe = ~wave;
  end

  assign irq_wave_out = 1'b0;

  always @(posedge core_clk_in) begin
    if (!rst_n_in)
      irq_wave_oe_out <= 1'b0;
    else
      irq_wave_oe_out <= next_oe;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data for the serial port; unknown offsets read zero
  always @* begin
    case (rd_addr)
      `RTCAL_OFS_A1_SEC: rd_data = a1_sec;
      `RTCAL_OFS_A1_MIN: rd_data = a1_min;
      `RTCAL_OFS_A1_HOUR: rd_data = a1_hour;
      `RTCAL_OFS_A1_DAY: rd_data = a1_day;
      `RTCAL_OFS_A2_MIN: rd_data = a2_min;
      `RTCAL_OFS_A2_HOUR: rd_data = a2_hour;
      `RTCAL_OFS_A2_DAY: rd_data = a2_day;
      `RTCAL_OFS_CTRL: rd_data = ctrl;
      `RTCAL_OFS_STAT: rd_data = {5'h00, compensation_busy_out,
                                  alarm_two_flag, alarm_one_flag};
      default: rd_data = 8'h00;
    endcase
  end

endmodule

// ### tb/rtcal_alarm_ctrl_assertions.sv
// Checker for the alarm, control and wave block, bound to its top.
// Assumes one core clock domain and the synchronous active-low reset.
`timescale 1ns/1ps

module rtcal_alarm_ctrl_chk #(
  parameter FORCE_TEMP_CONVERT_CYC = 50
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire on_battery_in,
  input wire sec_tick_out,
  input wire osc_run_out,
  input wire compensation_busy_out,
  input wire temp_convert_start_out,
  input wire irq_wave_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  int gap;
  int busy_len;

  ////////////////////////////////////////////////////////////////////////
  // Cycles since last tick; busy length counts running cycles only,
  // since a halt legally stretches a conversion
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      gap <= 0;
      busy_len <= 0;
    end else begin
      gap <= sec_tick_out ? 0 : gap + 1;
      busy_len <= !compensation_busy_out ? 0 :
        busy_len + (osc_run_out ? 1 : 0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_tick_pulse;
    sec_tick_out |=> !sec_tick_out;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("second tick longer than one cycle");
  // 32768 oscillator edges, each at least two core cycles apart
  property p_tick_gap;
    sec_tick_out |-> gap >= 65535;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("second tick too early");
  property p_start_busy;
    temp_convert_start_out |-> ##[0:2] compensation_busy_out;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy missing after conversion start");
  property p_busy_cause;
    $rose(compensation_busy_out) |->
      temp_convert_start_out || $past(temp_convert_start_out);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a start");
  property p_busy_len;
    $fell(compensation_busy_out) |->
      busy_len >= FORCE_TEMP_CONVERT_CYC - 1 && busy_len <= FORCE_TEMP_CONVERT_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("conversion length wrong");
  property p_main_runs;
    !on_battery_in [*5] |-> osc_run_out;
  endproperty
  a_main_runs: assert property (p_main_runs)
    else $error("oscillator halted on main supply");
  property p_halt_no_tick;
    !osc_run_out && $past(!osc_run_out) |-> !sec_tick_out;
  endproperty
  a_halt_no_tick: assert property (p_halt_no_tick)
    else $error("tick while halted");
  property p_halt_busy;
    !osc_run_out && $past(!osc_run_out) |->
      $stable(compensation_busy_out);
  endproperty
  a_halt_busy: assert property (p_halt_busy)
    else $error("busy moved while halted");
  property p_pin_low;
    irq_wave_out == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("pin data not low");
  c_tick: cover property (sec_tick_out);
  c_force_temp_convert: cover property ($fell(compensation_busy_out));
  c_halt: cover property (!osc_run_out);
endmodule

bind rtcal_alarm_ctrl rtcal_alarm_ctrl_chk #(
  .FORCE_TEMP_CONVERT_CYC(FORCE_TEMP_CONVERT_CYC)
) i_rtcal_alarm_ctrl_chk (
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .on_battery_in(on_battery_in),
  .sec_tick_out(sec_tick_out),
  .osc_run_out(osc_run_out),
  .compensation_busy_out(compensation_busy_out),
  .temp_convert_start_out(temp_convert_start_out),
  .irq_wave_out(irq_wave_out)
);

// ### tb/rtcal_host_model.sv
// Host model: serial register master, modes 1 and 3, one data byte a frame.
// Assumes the bench calls access; pins move on falling core edges.
`timescale 1ns/1ps

module rtcal_host_model (
  input wire core_clk_in,
  input wire dout_in,
  output reg sclk_out,
  output reg cs_n_out,
  output reg din_out
);
  logic idle;

  // Idle bus: clock parked high, select high
  initial begin
    idle = 1'b1;
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One byte MSB first, 800 ns a bit; read bit taken late because
  // the answer lags the leading edge by several core cycles
  task byte_io(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    for (i = 7; i >= 0; i--) begin
      @(negedge core_clk_in);
      sclk_out = ~idle;
      din_out = tx[i];
      repeat (4) @(negedge core_clk_in);
      sclk_out = idle;
      repeat (3) @(negedge core_clk_in);
      rx[i] = dout_in;
    end
  endtask

  // Parked clock level between frames picks mode 1 (low) or 3 (high)
  task set_mode(input logic level);
    @(negedge core_clk_in);
    idle = level;
    sclk_out = level;
    repeat (4) @(negedge core_clk_in);
  endtask

  // Address byte then data byte in one select window
  task access(input logic [7:0] a, input logic [7:0] d,
              output logic [7:0] q);
    logic [7:0] junk;
    @(negedge core_clk_in);
    cs_n_out = 1'b0;
    repeat (4) @(negedge core_clk_in);
    byte_io(a, junk);
    byte_io(d, q);
    repeat (8) @(negedge core_clk_in);
    cs_n_out = 1'b1;
    // Released line must not keep showing the last bit
    din_out = ~din_out;
    repeat (8) @(negedge core_clk_in);
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the alarm, control and wave block.
// Assumes the host model drives the serial port; time comes from regs.
`timescale 1ns/1ps

module testbench;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg osc = 1'b0;
  reg on_bat = 1'b0;
  reg below_pf = 1'b0;
  reg [7:0] cur_sec = 8'h00;
  reg [7:0] cur_min = 8'h34;
  reg [7:0] cur_hour = 8'h12;
  reg [7:0] cur_day = 8'h04;
  reg [7:0] cur_date = 8'h03;
  wire sclk, cs_n, din, dout, dout_oe, tick, osc_run, busy, oe;
  int fails = 0;
  int total_checks = 0;
  int k;
  logic [7:0] q;
  int exp_t [4] = '{0, 8, 32, 64};
  logic [7:0] av [7] = '{8'h00, 8'h34, 8'h12, 8'h03, 8'h34, 8'h12, 8'h43};

  // Core clock; oscillator as fast as the synchroniser allows, so a
  // second lasts 65536 core cycles instead of ten million
  initial forever #50 core_clk = ~core_clk;
  always @(negedge core_clk) osc <= ~osc;

  rtcal_alarm_ctrl #(
    .BUSY_DELAY_CYC(20),
    .FORCE_TEMP_CONVERT_CYC(400),
    .CNT_W(21)
  ) i_rtcal_alarm_ctrl (
    .core_clk_in(core_clk),
    .rst_n_in(rst_n),
    .osc_32k_in(osc),
    .on_battery_in(on_bat),
    .below_pf_in(below_pf),
    .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n),
    .spi_din_in(din),
    .spi_dout_out(dout),
    .spi_dout_oe_out(dout_oe),
    .cur_sec_in(cur_sec),
    .cur_min_in(cur_min),
    .cur_hour_in(cur_hour),
    .cur_day_in(cur_day),
    .cur_date_in(cur_date),
    .sec_tick_out(tick),
    .osc_run_out(osc_run),
    .compensation_busy_out(busy),
    .temp_convert_start_out(),
    .irq_wave_out(),
    .irq_wave_oe_out(oe)
  );

  rtcal_host_model i_rtcal_host_model (
    .core_clk_in(core_clk),
    // A released data line shows the inverse, so a missing enable shows up
    .dout_in(dout_oe ? dout : ~dout),
    .sclk_out(sclk),
    .cs_n_out(cs_n),
    .din_out(din)
  );

  ////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [7:0] seen,
             input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    i_rtcal_host_model.access({1'b1, a}, d, q);
  endtask
  task rdc(input logic [6:0] a, input logic [7:0] e);
    i_rtcal_host_model.access({1'b0, a}, 8'h00, q);
    check($sformatf("reg %h", a), q, e);
  endtask
  // Pin edges over 256 cycles, one edge of slack for window phase
  task wave(input int e);
    int t;
    logic prev;
    t = 0;
    prev = oe;
    repeat (256) begin
      @(negedge core_clk);
      if (oe !== prev) t++;
      prev = oe;
    end
    check("wave edges", {7'h00, t >= e - 1 && t <= e + 1}, 8'h01);
  endtask
  task test_done;
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    rdc(7'h0e, 8'h1c);
    rdc(7'h0f, 8'h00);
    rdc(7'h20, 8'h00);
    // Stop bit only halts on battery; halted writes are lost
    wr(7'h0e, 8'h9c);
    repeat (10) @(negedge core_clk);
    check("osc run", {7'h00, osc_run}, 8'h01);
    on_bat = 1'b1;
    repeat (10) @(negedge core_clk);
    check("osc run", {7'h00, osc_run}, 8'h00);
    wr(7'h07, 8'h55);
    on_bat = 1'b0;
    repeat (10) @(negedge core_clk);
    check("osc run", {7'h00, osc_run}, 8'h01);
    rdc(7'h07, 8'h00);
    // Host conversion; convert bit reads set until busy drops
    wr(7'h0e, 8'h3c);
    for (k = 0; k < 200 && busy !== 1'b1; k++) @(negedge core_clk);
    check("busy", {7'h00, busy}, 8'h01);
    rdc(7'h0e, 8'h3c);
    for (k = 0; k < 600 && busy !== 1'b0; k++) @(negedge core_clk);
    rdc(7'h0e, 8'h1c);
    rdc(7'h0f, 8'h00);
    // Every wave rate, then the backup-supply gating
    for (k = 0; k < 4; k++) begin
      wr(7'h0e, {3'b000, k[1:0], 3'b000});
      wave(exp_t[k]);
    end
    below_pf = 1'b1;
    // Supply sync and pin register settle before edges are counted
    repeat (4) @(negedge core_clk);
    wave(0);
    check("pin", {7'h00, oe}, 8'h00);
    wr(7'h0e, 8'h58);
    wave(64);
    below_pf = 1'b0;
    // Alarm one on date; alarm two on a differing weekday; port in mode 1
    i_rtcal_host_model.set_mode(1'b0);
    for (k = 0; k < 7; k++) wr(7'(7 + k), av[k]);
    for (k = 0; k < 7; k++) rdc(7'(7 + k), av[k]);
    wr(7'h0e, 8'h06);
    rdc(7'h0f, 8'h00);
    for (k = 0; k < 80000 && tick !== 1'b1; k++) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
    check("pin", {7'h00, oe}, 8'h00);
    rdc(7'h0f, 8'h01);
    wr(7'h0e, 8'h05);
    check("pin", {7'h00, oe}, 8'h01);
    wr(7'h0f, 8'h01);
    rdc(7'h0f, 8'h01);
    check("pin", {7'h00, oe}, 8'h01);
    // Select zero hands the pin to the wave despite the enabled flag
    wr(7'h0e, 8'h09);
    wave(8);
    wr(7'h0e, 8'h05);
    wr(7'h0f, 8'h00);
    check("pin", {7'h00, oe}, 8'h00);
    rdc(7'h0f, 8'h00);
    test_done;
  end

  // Watchdog: one simulated second plus setup fits well inside
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    test_done;
  end
endmodule
